//--- rtl/sfsr_defs.svh
// constants for the serial flash status register block
// assumes: included by bare name from the rtl files, no other defines of these names
// What this block does
// - after the read-status opcode, one status bit leaves on every clock
// - msb first; byte one bit 0 runs straight into byte two bit 7
// - after byte two bit 0 the two-byte sequence restarts while selected
// - every repetition carries freshly sampled status, never a stale copy
// - read-status is answered at any time, also while busy
// - chip select released anywhere ends the read and floats the output
// - byte one bits 6 and 3 are reserved and read zero
// - only lock bit 7 and protect bit 2 are writable by write-status
// - lock set and protect pin asserted freezes the array-protect bit
// - lock bit resets to zero; then array-protect stays modifiable
// - with protect pin asserted, lock may only rise; pin released frees it
// - fail flag set on any bad byte, updated after every program/erase
// - an aborted program or erase never sets the fail flag
// - bit 4 reads zero while protect pin asserted, one otherwise
// - array-protect one protects the whole array, zero protects nothing
// - write latch zero rejects write-status here; program, erase, otp program are gated outside this block
// - write latch clears after power-up and any reset operation
// - latch clears on write-disable and on end or abort of writing commands
// - incomplete or unknown opcode abort leaves a set latch untouched
// - bit 0 shows busy, present in both status bytes
// - byte two bit 4 is soft-reset allow, bit 0 is busy, other byte two bits read zero
// - write-status opcode plus one byte applies at deselect, clears latch
`ifndef SFSR_DEFS_SVH
`define SFSR_DEFS_SVH
`define SFSR_OP_READ_STATUS 8'h05
`define SFSR_OP_WRITE_STATUS 8'h01
`define SFSR_B1_LOCK 7
`define SFSR_B1_FAIL 5
`define SFSR_B1_PIN 4
`define SFSR_B1_PROTECT 2
`define SFSR_B1_LATCH 1
`define SFSR_B_BUSY 0
`define SFSR_B2_RESET_ALLOW 4
`define SFSR_RST_LOCK 1'b0
`define SFSR_RST_PROTECT 1'b0
`define SFSR_RST_LATCH 1'b0
`define SFSR_RST_FAIL 1'b0
`define SFSR_RST_BYTE1 8'h10
`define SFSR_SYNC_STAGES 2
`endif

//--- rtl/sfsr_pkg.sv
// types shared by the status register block
// assumes: compiled before the interface and the modules
package sfsr_pkg;
  typedef logic [7:0] sfsr_byte_t;
  typedef logic [3:0] sfsr_bitpos_t;
  typedef enum logic [2:0] {
    SF_IDLE,
    SF_READ,
    SF_WSTAT,
    SF_WDATA,
    SF_SKIP
  } sfsr_cmd_e;
endpackage : sfsr_pkg

//--- rtl/sfsr_link_if.sv
// carrier between the serial front end and the status core
// assumes: all signals on i_core_clk, pulses last one cycle
interface sfsr_link_if;
  logic cs_act;
  logic cs_end;
  logic sck_rise;
  logic sck_fall;
  logic byte_done;
  logic [7:0] rx_byte;
  logic [2:0] bit_cnt;
  logic first_byte;
  logic wp_n;
  modport rx (output cs_act, cs_end, sck_rise, sck_fall, byte_done, rx_byte, bit_cnt,
              first_byte, wp_n);
  modport core (input cs_act, cs_end, sck_rise, sck_fall, byte_done, rx_byte, bit_cnt,
                first_byte, wp_n);
endinterface : sfsr_link_if

//--- rtl/sfsr_spi_rx.sv
// serial front end: pin synchronisers, clock edge finder, byte receiver
// assumes: pins asynchronous to i_core_clk, serial clock well below core clock
`include "sfsr_defs.svh"
module sfsr_spi_rx (
  input wire logic i_core_clk, // core clock
  input wire logic i_rst,      // sync reset, high
  input wire logic i_ce,       // clock enable
  input wire logic i_cs_n,     // chip select pin, low active
  input wire logic i_sck,      // serial clock pin
  input wire logic i_si,       // serial data in pin
  input wire logic i_wp_n,     // write protect pin, low active
  sfsr_link_if.rx lk           // to the status core
);
  // ----------------------------------------
  // two-stage synchronisers
  // ----------------------------------------
  logic [`SFSR_SYNC_STAGES-1:0] cs_n_sync_reg;
  logic [`SFSR_SYNC_STAGES-1:0] sck_sync_reg;
  logic [`SFSR_SYNC_STAGES-1:0] si_sync_reg;
  logic [`SFSR_SYNC_STAGES-1:0] wp_n_sync_reg;
  logic cs_n_dly_reg;
  logic sck_dly_reg;
  logic [6:0] shift_reg;
  logic [2:0] bit_cnt_reg;
  logic first_byte_reg;
  logic cs_start;

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cs_n_sync_reg <= '1;
      sck_sync_reg <= '0;
      si_sync_reg <= '0;
      wp_n_sync_reg <= '1;
      cs_n_dly_reg <= 1'b1;
      sck_dly_reg <= 1'b0;
    end else if (i_ce) begin
      cs_n_sync_reg <= {cs_n_sync_reg[0], i_cs_n};
      sck_sync_reg <= {sck_sync_reg[0], i_sck};
      si_sync_reg <= {si_sync_reg[0], i_si};
      wp_n_sync_reg <= {wp_n_sync_reg[0], i_wp_n};
      cs_n_dly_reg <= cs_n_sync_reg[1];
      sck_dly_reg <= sck_sync_reg[1];
    end
  end

  assign cs_start = !cs_n_sync_reg[1] && cs_n_dly_reg;
  assign lk.cs_act = !cs_n_sync_reg[1];
  assign lk.cs_end = cs_n_sync_reg[1] && !cs_n_dly_reg;
  assign lk.sck_rise = sck_sync_reg[1] && !sck_dly_reg && !cs_n_sync_reg[1];
  assign lk.sck_fall = !sck_sync_reg[1] && sck_dly_reg && !cs_n_sync_reg[1];
  assign lk.wp_n = wp_n_sync_reg[1];

  // ----------------------------------------
  // byte receiver, sampled on rising edges
  // ----------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      shift_reg <= '0;
      bit_cnt_reg <= '0;
      first_byte_reg <= 1'b1;
    end else if (i_ce) begin
      if (cs_start) begin
        bit_cnt_reg <= '0;
        first_byte_reg <= 1'b1;
      end else if (lk.sck_rise) begin
        shift_reg <= {shift_reg[5:0], si_sync_reg[1]};
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
        if (bit_cnt_reg == 3'h7) begin
          first_byte_reg <= 1'b0;
        end
      end
    end
  end

  assign lk.bit_cnt = bit_cnt_reg;
  assign lk.first_byte = first_byte_reg;
  assign lk.byte_done = lk.sck_rise && (bit_cnt_reg == 3'h7);
  assign lk.rx_byte = {shift_reg, si_sync_reg[1]};
endmodule : sfsr_spi_rx

//--- rtl/sfsr_top.sv
// status register core of a serial flash: read-status stream, write-status, flags
// assumes: program/erase engine, write-enable decode and soft reset live outside
`include "sfsr_defs.svh"
module sfsr_top (
  input wire logic i_core_clk,                 // core clock, 125 MHz
  input wire logic i_rst,                      // sync reset, high
  input wire logic i_ce,                       // clock enable, low freezes state
  input wire logic i_cs_n,                     // chip select pin, low active
  input wire logic i_sck,                      // serial clock pin
  input wire logic i_si,                       // serial data in pin
  input wire logic i_wp_n,                     // write protect pin, low active
  input wire logic i_busy,                     // program/erase engine running
  input wire logic i_op_done,                  // program/erase finished, pulse
  input wire logic i_op_fail,                  // with i_op_done: a byte failed
  input wire logic i_op_abort,                 // writing command aborted, pulse
  input wire logic i_wel_set,                  // write enable command done, pulse
  input wire logic i_wel_clr,                  // write disable done, pulse
  input wire logic i_hold_abort,               // hold condition aborted, pulse
  input wire logic i_dev_reset,                // reset operation, pulse
  input wire logic i_soft_reset_allow,         // soft reset enable bit
  output logic o_so,                           // serial data out
  output logic o_so_oe,                        // serial out drive enable
  output logic o_write_latch_bit,              // writing commands accepted
  output logic o_array_protected,              // whole array protected
  output logic o_protect_lock_bit,             // lock state
  output logic o_program_fail_flag,            // last program/erase failed
  output sfsr_pkg::sfsr_byte_t o_status_byte1  // live status byte one
);
  import sfsr_pkg::*;

  sfsr_link_if lk ();

  sfsr_spi_rx u_rx (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_ce(i_ce),
    .i_cs_n(i_cs_n),
    .i_sck(i_sck),
    .i_si(i_si),
    .i_wp_n(i_wp_n),
    .lk(lk)
  );

  sfsr_cmd_e cmd_reg;
  sfsr_byte_t data_reg;
  sfsr_byte_t byte1;
  sfsr_byte_t byte2;
  sfsr_byte_t byte1_reg;
  sfsr_bitpos_t out_cnt_reg;
  logic lock_reg;
  logic protect_reg;
  logic latch_reg;
  logic fail_reg;
  logic so_reg;
  logic drive_reg;
  logic wp_on;
  logic wstat_end;
  logic wr_whole;
  logic lock_clear_blocked;
  logic wr_apply;
  logic latch_clear;

  // picks one bit of the two-byte stream, msb of byte one first
  function automatic logic status_bit(input sfsr_bitpos_t pos, input sfsr_byte_t b1,
                                      input sfsr_byte_t b2);
    logic [2:0] idx;
    idx = 3'h7 - pos[2:0];
    return pos[3] ? b2[idx] : b1[idx];
  endfunction : status_bit

  // ----------------------------------------
  // live status bytes
  // ----------------------------------------
  assign wp_on = !lk.wp_n;

  // reserved zero, pin level, busy in both
  always_comb begin
    byte1 = 8'h00;
    byte1[`SFSR_B1_LOCK] = lock_reg;
    byte1[`SFSR_B1_FAIL] = fail_reg;
    byte1[`SFSR_B1_PIN] = lk.wp_n;
    byte1[`SFSR_B1_PROTECT] = protect_reg;
    byte1[`SFSR_B1_LATCH] = latch_reg;
    byte1[`SFSR_B_BUSY] = i_busy;
  end

  always_comb begin
    byte2 = 8'h00;
    byte2[`SFSR_B2_RESET_ALLOW] = i_soft_reset_allow;
    byte2[`SFSR_B_BUSY] = i_busy;
  end

  // data output taken from a flop; pin bit idles high like its synchroniser
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      byte1_reg <= `SFSR_RST_BYTE1;
    end else if (i_ce) begin
      byte1_reg <= byte1;
    end
  end

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  // read accepted regardless of busy; write-status needs latch
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      cmd_reg <= SF_IDLE;
      data_reg <= 8'h00;
    end else if (i_ce) begin
      if (!lk.cs_act) begin
        cmd_reg <= SF_IDLE;
      end else if (lk.byte_done) begin
        unique case (cmd_reg)
          SF_IDLE: begin
            if (lk.rx_byte == `SFSR_OP_READ_STATUS) begin
              cmd_reg <= SF_READ;
            end else if (lk.rx_byte == `SFSR_OP_WRITE_STATUS && latch_reg) begin
              cmd_reg <= SF_WSTAT;
            end else begin
              cmd_reg <= SF_SKIP;
            end
          end
          SF_WSTAT: begin
            data_reg <= lk.rx_byte;
            cmd_reg <= SF_WDATA;
          end
          SF_READ, SF_WDATA, SF_SKIP: begin
            cmd_reg <= cmd_reg;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // write-status commit at deselect
  // ----------------------------------------
  // applied only on a whole byte boundary
  assign wstat_end = lk.cs_end && (cmd_reg == SF_WSTAT || cmd_reg == SF_WDATA);
  assign wr_whole = lk.cs_end && cmd_reg == SF_WDATA && lk.bit_cnt == 3'h0;
  // clearing the lock needs the pin released
  assign lock_clear_blocked = wp_on && lock_reg && !data_reg[`SFSR_B1_LOCK];
  assign wr_apply = wr_whole && !lock_clear_blocked;

  // lock bit written; resets to zero
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      lock_reg <= `SFSR_RST_LOCK;
    end else if (i_ce && wr_apply) begin
      lock_reg <= data_reg[`SFSR_B1_LOCK];
    end
  end

  // protect frozen while locked with pin asserted; whole array
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      protect_reg <= `SFSR_RST_PROTECT;
    end else if (i_ce && wr_apply && !(lock_reg && wp_on)) begin
      protect_reg <= data_reg[`SFSR_B1_PROTECT];
    end
  end

  // ----------------------------------------
  // write enable latch
  // ----------------------------------------
  // clear events; skipped opcodes do not clear
  assign latch_clear = i_wel_clr || i_op_done || i_op_abort || i_hold_abort || wstat_end;

  // reset and reset operation clear; set wins over a clear
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      latch_reg <= `SFSR_RST_LATCH;
    end else if (i_ce) begin
      if (i_wel_set) begin
        latch_reg <= 1'b1;
      end else if (latch_clear || i_dev_reset) begin
        latch_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // program/erase fail flag
  // ----------------------------------------
  // updated per finished operation; aborts leave it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      fail_reg <= `SFSR_RST_FAIL;
    end else if (i_ce && i_op_done) begin
      fail_reg <= i_op_fail;
    end
  end

  // ----------------------------------------
  // status stream out
  // ----------------------------------------
  // one bit per falling edge; wraps over 16 bits
  // each bit taken from the live bytes
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      out_cnt_reg <= 4'h0;
      so_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else if (i_ce) begin
      if (!lk.cs_act) begin
        out_cnt_reg <= 4'h0;
        drive_reg <= 1'b0;
      end else if (cmd_reg == SF_READ && lk.sck_fall) begin
        so_reg <= status_bit(out_cnt_reg, byte1, byte2);
        out_cnt_reg <= out_cnt_reg + 4'h1;
        drive_reg <= 1'b1;
      end
    end
  end

  // float as soon as select drops
  assign o_so_oe = drive_reg && lk.cs_act;
  assign o_so = so_reg;
  assign o_write_latch_bit = latch_reg;
  assign o_array_protected = protect_reg;
  assign o_protect_lock_bit = lock_reg;
  assign o_program_fail_flag = fail_reg;
  assign o_status_byte1 = byte1_reg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  property p_float_off;
    @(posedge i_core_clk) disable iff (i_rst) !lk.cs_act |-> !o_so_oe;
  endproperty
  a_float_off: assert property (p_float_off) else $error("output driven while deselected");

  property p_reserved;
    @(posedge i_core_clk) disable iff (i_rst)
      o_status_byte1[6] == 1'b0 && o_status_byte1[3] == 1'b0 && byte2[7:5] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status bit set");

  property p_pin_level;
    @(posedge i_core_clk) disable iff (i_rst)
      $past(i_ce) |-> o_status_byte1[`SFSR_B1_PIN] == $past(lk.wp_n);
  endproperty
  a_pin_level: assert property (p_pin_level) else $error("pin level bit wrong");

  property p_latch_reset;
    @(posedge i_core_clk) i_rst |=> !latch_reg && !lock_reg;
  endproperty
  a_latch_reset: assert property (p_latch_reset) else $error("latch or lock not reset");

  property p_fail_update;
    @(posedge i_core_clk) disable iff (i_rst) i_ce && i_op_done |=> fail_reg == $past(i_op_fail);
  endproperty
  a_fail_update: assert property (p_fail_update) else $error("fail flag not updated");

  property p_fail_abort;
    @(posedge i_core_clk) disable iff (i_rst) i_op_abort && !i_op_done |=> $stable(fail_reg);
  endproperty
  a_fail_abort: assert property (p_fail_abort) else $error("abort changed fail flag");

  property p_lock_freeze;
    @(posedge i_core_clk) disable iff (i_rst) lock_reg && wp_on |=> $stable(protect_reg);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked protect changed");

  property p_lock_fall;
    @(posedge i_core_clk) disable iff (i_rst) ##1 $fell(lock_reg) |-> $past(lk.wp_n);
  endproperty
  a_lock_fall: assert property (p_lock_fall) else $error("lock cleared with pin on");

  property p_wstat_latch;
    @(posedge i_core_clk) disable iff (i_rst) i_ce && wstat_end && !i_wel_set |=> !latch_reg;
  endproperty
  a_wstat_latch: assert property (p_wstat_latch) else $error("latch kept after write");

  property p_skip_keep;
    @(posedge i_core_clk) disable iff (i_rst)
      lk.cs_end && cmd_reg == SF_SKIP && latch_reg && !i_wel_clr && !i_op_done && !i_op_abort
      && !i_hold_abort && !i_dev_reset |=> latch_reg;
  endproperty
  a_skip_keep: assert property (p_skip_keep) else $error("latch lost on bad opcode");

  property p_byte2_top;
    @(posedge i_core_clk) disable iff (i_rst)
      i_ce && cmd_reg == SF_READ && lk.cs_act && lk.sck_fall && out_cnt_reg == 4'h8 |=> !o_so;
  endproperty
  a_byte2_top: assert property (p_byte2_top) else $error("byte two bit 7 not zero");

  property p_wrap;
    @(posedge i_core_clk) disable iff (i_rst)
      i_ce && cmd_reg == SF_READ && lk.cs_act && lk.sck_fall && out_cnt_reg == 4'hf
      |=> out_cnt_reg == 4'h0 && o_so == $past(i_busy);
  endproperty
  a_wrap: assert property (p_wrap) else $error("stream did not wrap");

  property p_busy_both;
    @(posedge i_core_clk) disable iff (i_rst)
      i_ce && cmd_reg == SF_READ && lk.cs_act && lk.sck_fall && out_cnt_reg[2:0] == 3'h7
      |=> o_so == $past(i_busy);
  endproperty
  a_busy_both: assert property (p_busy_both) else $error("busy bit missing from a byte");

  property p_step;
    @(posedge i_core_clk) disable iff (i_rst)
      i_ce && cmd_reg == SF_READ && lk.cs_act && lk.sck_fall
      |=> drive_reg && out_cnt_reg == $past(out_cnt_reg) + 4'h1;
  endproperty
  a_step: assert property (p_step) else $error("status stream skipped a bit");

  property p_wstat_gate;
    @(posedge i_core_clk) disable iff (i_rst)
      i_ce && lk.byte_done && cmd_reg == SF_IDLE && !latch_reg |=> cmd_reg != SF_WSTAT;
  endproperty
  a_wstat_gate: assert property (p_wstat_gate) else $error("write-status without latch");

  property p_first_byte;
    @(posedge i_core_clk) disable iff (i_rst)
      lk.byte_done && cmd_reg == SF_IDLE |-> lk.first_byte;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("opcode decoded late");

  c_full_read: cover property (@(posedge i_core_clk) cmd_reg == SF_READ && out_cnt_reg == 4'hf);
  c_write_apply: cover property (@(posedge i_core_clk) i_ce && wr_apply);
  c_write_blocked: cover property (@(posedge i_core_clk) i_ce && wr_whole && lock_clear_blocked);
  c_busy_drop: cover property (@(posedge i_core_clk) cmd_reg == SF_READ && $fell(i_busy));
  c_lock_frozen: cover property (@(posedge i_core_clk) i_ce && wr_apply && lock_reg && wp_on);
endmodule : sfsr_top

//--- verification/sfsr_host_model.sv
// host side model: drives chip select, serial clock and data in, samples serial out
// assumes: mode 0 framing, 125 ns serial clock, the bench pushes expected bits itself
module sfsr_host_model (
  output logic o_cs_n,       // chip select, low active
  output logic o_sck,        // serial clock, low outside frames
  output logic o_si,         // serial data to device
  input wire logic i_so,     // serial data from device
  input wire logic i_so_oe   // device drives serial out
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;
  event bit_ev;
  logic bit_val;
  int n_bits = 0;

  initial begin
    o_cs_n = 1'b1;
    o_sck = 1'b0;
    o_si = 1'b0;
  end

  // ----------------------------------------
  // frame engine
  // ----------------------------------------
  task automatic send_bit(input logic b);
    o_si = b;
    #HALF;
    o_sck = 1'b1;
    #HALF;
    o_sck = 1'b0;
  endtask : send_bit

  task automatic frame(input logic [7:0] op, input int nop, input logic [7:0] d,
                       input int nd, input int nr);
    o_cs_n = 1'b0;
    #HALF;
    for (int i = 0; i < nop; i++) send_bit(op[7 - i]);
    for (int i = 0; i < nd; i++) send_bit(d[7 - i]);
    for (int i = 0; i < nr; i++) begin
      o_si = ~o_si;
      #HALF;
      o_sck = 1'b1;
      bit_val = (i_so_oe === 1'b1) ? i_so : 1'bx;
      n_bits++;
      -> bit_ev;
      #HALF;
      o_sck = 1'b0;
    end
    #HALF;
    o_cs_n = 1'b1;
    o_si = ~o_si;
    #100;
  endtask : frame
endmodule : sfsr_host_model

//--- verification/testbench.sv
// self-checking bench for the status register block
// assumes: status is observed through the read-status stream of the host model and the dut status outputs
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_core_clk = 1'b0;
  logic i_rst, i_ce, i_wp_n, i_busy, i_op_done, i_op_fail, i_op_abort;
  logic i_wel_set, i_wel_clr, i_hold_abort, i_dev_reset, i_soft_reset_allow;
  logic cs_n, sck, si, so, so_oe;
  logic e_lock, e_prot, e_latch, e_fail;
  logic latch_o, prot_o, lock_o, fail_o;
  logic [7:0] st1_o;
  logic exp_q[$];
  logic [31:0] rng = 32'h44;
  logic [31:0] r;
  logic [7:0] b;
  int n_mismatch = 0;
  int n_compared = 0;
  int n0;

  always #4 i_core_clk = ~i_core_clk;

  sfsr_top dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_ce(i_ce), .i_cs_n(cs_n),
    .i_sck(sck), .i_si(si), .i_wp_n(i_wp_n), .i_busy(i_busy), .i_op_done(i_op_done),
    .i_op_fail(i_op_fail), .i_op_abort(i_op_abort), .i_wel_set(i_wel_set),
    .i_wel_clr(i_wel_clr), .i_hold_abort(i_hold_abort), .i_dev_reset(i_dev_reset),
    .i_soft_reset_allow(i_soft_reset_allow), .o_so(so), .o_so_oe(so_oe),
    .o_write_latch_bit(latch_o), .o_array_protected(prot_o), .o_protect_lock_bit(lock_o),
    .o_program_fail_flag(fail_o), .o_status_byte1(st1_o));

  sfsr_host_model host (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so), .i_so_oe(so_oe));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xorshift();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xorshift

  function automatic logic [7:0] st1();
    return {e_lock, 1'b0, e_fail, i_wp_n, 1'b0, e_prot, e_latch, i_busy};
  endfunction : st1

  function automatic logic [7:0] st2();
    return {3'b000, i_soft_reset_allow, 3'b000, i_busy};
  endfunction : st2

  task automatic push_byte(input logic [7:0] v);
    for (int i = 7; i >= 0; i--) exp_q.push_back(v[i]);
  endtask : push_byte

  task automatic chk();
    @(negedge i_core_clk);
    n_compared++;
    if ({st1_o, lock_o, prot_o, latch_o, fail_o} !==
        {st1(), e_lock, e_prot, e_latch, e_fail}) begin
      n_mismatch++;
      $display("BAD %0t status outputs differ", $time);
    end
    push_byte(st1());
    push_byte(st2());
    host.frame(8'h05, 8, 8'h00, 0, 16);
  endtask : chk

  task automatic pulse(input int k);
    @(posedge i_core_clk);
    r = xorshift();
    i_ce <= r[0];
    case (k)
      0: i_wel_set <= 1'b1;
      1: i_wel_clr <= 1'b1;
      2: i_hold_abort <= 1'b1;
      3: i_dev_reset <= 1'b1;
      4: i_op_abort <= 1'b1;
      default: i_op_done <= 1'b1;
    endcase
    @(posedge i_core_clk);
    i_ce <= 1'b1;
    @(negedge i_core_clk);
    if (!r[0]) begin
      n_compared++;
      if (latch_o !== e_latch || fail_o !== e_fail) begin
        n_mismatch++;
        $display("BAD %0t state moved while clock enable low", $time);
      end
    end
    @(posedge i_core_clk);
    {i_wel_set, i_wel_clr, i_hold_abort, i_dev_reset, i_op_abort, i_op_done} <= 6'h00;
    @(posedge i_core_clk);
    e_latch = (k == 0);
    if (k == 5) e_fail = i_op_fail;
  endtask : pulse

  task automatic wstat(input logic [7:0] d, input int nd);
    host.frame(8'h01, 8, d, nd, 0);
    if (e_latch) begin
      if (nd == 8 && !(!i_wp_n && e_lock && !d[7])) begin
        if (!(e_lock && !i_wp_n)) e_prot = d[2];
        e_lock = d[7];
      end
      e_latch = 1'b0;
    end
  endtask : wstat

  task automatic setwp(input logic v);
    @(posedge i_core_clk);
    i_wp_n <= v;
    repeat (4) @(posedge i_core_clk);
  endtask : setwp

  task automatic complete_run();
    if (exp_q.size() != 0) begin
      n_mismatch++;
      $display("BAD %0t expected status bits never arrived", $time);
    end
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // result watcher
  // ----------------------------------------
  always @(host.bit_ev) begin
    n_compared++;
    if (exp_q.size() == 0) begin
      n_mismatch++;
      $display("BAD %0t unexpected status bit", $time);
    end else if (host.bit_val !== exp_q.pop_front()) begin
      n_mismatch++;
      $display("BAD %0t status bit differs", $time);
    end
  end

  initial begin
    #500us;
    n_mismatch++;
    $display("BAD %0t watchdog expired", $time);
    complete_run();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {i_busy, i_op_done, i_op_fail, i_op_abort, i_soft_reset_allow} = 5'h00;
    {i_wel_set, i_wel_clr, i_hold_abort, i_dev_reset} = 4'h0;
    {e_lock, e_prot, e_latch, e_fail} = 4'h0;
    i_rst = 1'b1;
    i_ce = 1'b1;
    i_wp_n = 1'b1;
    repeat (10) @(posedge i_core_clk);
    r = xorshift();
    i_rst <= 1'b0;
    i_soft_reset_allow <= r[0];
    i_busy <= 1'b1;
    repeat (3) @(posedge i_core_clk);
    push_byte(st1());
    push_byte(st2());
    push_byte(st1() & 8'hfe);
    push_byte(st2() & 8'hfe);
    n0 = host.n_bits;
    fork
      host.frame(8'h05, 8, 8'h00, 0, 32);
      begin
        wait (host.n_bits == n0 + 16);
        @(posedge i_core_clk);
        i_busy <= 1'b0;
      end
    join
    wstat(8'h84, 8);
    chk();
    pulse(0);
    r = xorshift();
    wstat((r[7:0] & 8'h7b) | 8'h84, 8);
    chk();
    setwp(1'b0);
    pulse(0);
    wstat(8'h80, 8);
    chk();
    pulse(0);
    wstat(8'h00, 8);
    chk();
    setwp(1'b1);
    pulse(0);
    wstat(8'h00, 8);
    chk();
    setwp(1'b0);
    pulse(0);
    wstat(8'h04, 8);
    chk();
    setwp(1'b1);
    pulse(0);
    wstat(8'h80, 5);
    chk();
    pulse(0);
    host.frame(8'h01, 5, 8'h00, 0, 0);
    chk();
    @(posedge i_core_clk);
    i_op_fail <= 1'b1;
    pulse(5);
    chk();
    pulse(0);
    pulse(4);
    chk();
    @(posedge i_core_clk);
    i_op_fail <= 1'b0;
    pulse(5);
    chk();
    for (int k = 1; k < 4; k++) begin
      pulse(0);
      pulse(k);
      chk();
    end
    b = st1();
    for (int i = 7; i > 4; i--) exp_q.push_back(b[i]);
    host.frame(8'h05, 8, 8'h00, 0, 3);
    n_compared++;
    if (so_oe !== 1'b0) begin
      n_mismatch++;
      $display("BAD %0t serial out still driven after deselect", $time);
    end
    complete_run();
  end
endmodule : testbench
